// ### apb_host_model.sv
// management host model: apb master with word transfers and threshold policy
// assumes pclk from the bench and a slave that may stretch the access phase
module apb_host_model (
   input  wire logic        pclk,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   // shorter gaps need a lower idle threshold
   task automatic set_threshold(input int gap);
      xfer(1'b1, 32'h14C, (gap < 12) ? 32'h4 : 32'h5, 4'h1);
   endtask : set_threshold
endmodule : apb_host_model

// ### phy_datapath_tuning_regs.sv
// apb register bank for rgmii latency, sgmii negotiation status, 100 mb/s receive options
// and the trellis idle detector; also hosts the descrambler watchdog and idle counter
// assumes apb master in pclk domain; datapath symbol strobes synchronous to pclk
//
// Contract
// - bypass bit set routes receive data around the async fifo
// - clock delay bypass bit set bypasses the receive clock delay at 10/100
// - low latency bit set enables the 10/100 low latency path
// - page received status bit reads 1 once a page arrived
// - negotiation done status bit reads 1 when negotiation finished
// - negotiation status bits 15:2 ignore writes and read zero
// - watchdog clear aborts packets longer than 1.5 ms; set disables it
// - recovery time field in ms after descrambler unlock, resets to 1111
// - force link bit set forces good 100 mb/s link indication
// - enhanced three level detect resets to 1, writable
// - enhanced gap detect enables when set, resets to 0
// - scrambler off bit set disables the 100 mb/s scrambler
// - odd nibble bit set enables odd nibble detection
// - early receive valid bit set asserts receive valid early
// - idle mode entered after consecutive idles reach the threshold, default 5
module phy_datapath_tuning_regs #(
   parameter int WATCHDOG_CYCLES = phy_tuning_pkg::WATCHDOG_CYCLES,
   parameter int MS_CYCLES       = phy_tuning_pkg::MS_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sgmii_page_rx,
   input  wire logic        sgmii_neg_done,
   input  wire logic        rx_symbol_valid,
   input  wire logic        rx_symbol_idle,
   input  wire logic        rx_packet_active,
   input  wire logic        descrambler_locked,
   output logic             receive_fifo_bypass_enable,
   output logic             bypass_receive_clock_delay_enable,
   output logic             low_latency_enable,
   output logic             force_link_good,
   output logic             enhanced_three_level_detect_enable,
   output logic             enhanced_gap_detect_enable,
   output logic             scrambler_off,
   output logic             odd_nibble_detect_enable,
   output logic             early_receive_valid_enable,
   output logic             rx_packet_abort,
   output logic             rx_recovering,
   output logic             idle_mode
);

   phy_tuning_pkg::tuning_cfg_s cfg_q, cfg_d;
   logic        page_q, page_d, done_q, done_d;
   logic [31:0] prdata_q, prdata_d;
   logic        slverr_q, slverr_d;
   logic        access, wr, lo_en;
   logic [11:0] idx;
   logic        hit;
   logic [15:0] rd_word;

   assign access = psel & penable;
   assign wr     = access & pwrite;
   assign idx    = paddr[13:2];
   assign lo_en  = pstrb[0];
   assign pready = 1'b1;

   // read mux; reserved fields give their fixed value
   always_comb begin
      rd_word = 16'h0000;
      hit     = 1'b1;
      case (idx)
         phy_tuning_pkg::IDX_RGMII_LATENCY: begin
            rd_word[phy_tuning_pkg::RL_FIFO_BYPASS_BIT] = cfg_q.fifo_bypass;
            rd_word[phy_tuning_pkg::RL_CLK_DELAY_BIT]   = cfg_q.bypass_clk_delay;
            rd_word[phy_tuning_pkg::RL_LOW_LAT_BIT]     = cfg_q.low_latency;
         end
         phy_tuning_pkg::IDX_SERIAL_NEG_STS: begin
            rd_word[phy_tuning_pkg::NS_PAGE_RX_BIT] = page_q;
            rd_word[phy_tuning_pkg::NS_DONE_BIT]    = done_q;
         end
         phy_tuning_pkg::IDX_FE_RX_CONFIG: begin
            rd_word[phy_tuning_pkg::FE_WDOG_DIS_BIT] = cfg_q.watchdog_disable;
            rd_word[phy_tuning_pkg::FE_RECOV_MSB:phy_tuning_pkg::FE_RECOV_LSB] = cfg_q.recovery_time;
            rd_word[phy_tuning_pkg::FE_FORCE_LINK]    = cfg_q.force_link;
            rd_word[phy_tuning_pkg::FE_MLT3_BIT]      = cfg_q.mlt3_enh;
            rd_word[phy_tuning_pkg::FE_GAP_BIT]       = cfg_q.gap_enh;
            rd_word[phy_tuning_pkg::FE_SCR_OFF_BIT]   = cfg_q.scrambler_off;
            rd_word[phy_tuning_pkg::FE_ODD_NIB_BIT]   = cfg_q.odd_nibble;
            rd_word[phy_tuning_pkg::FE_EARLY_RXV_BIT] = cfg_q.early_rxv;
         end
         phy_tuning_pkg::IDX_FE_RX_STATUS: begin
            rd_word[1] = rx_recovering;
            rd_word[0] = idle_mode;
         end
         phy_tuning_pkg::IDX_TRELLIS_CFG: begin
            rd_word = {phy_tuning_pkg::TD_FIXED_UPPER, cfg_q.idle_thresh};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // register writes; upper byte lane needed only for the watchdog disable bit and the recovery field msbs
   always_comb begin
      cfg_d    = cfg_q;
      prdata_d = prdata_q;
      slverr_d = 1'b0;
      if (access) begin
         slverr_d = ~hit;
         if (!pwrite) begin
            prdata_d = {16'h0000, rd_word};
         end
      end
      if (wr && hit) begin
         case (idx)
            phy_tuning_pkg::IDX_RGMII_LATENCY: begin
               if (lo_en) begin
                  cfg_d.fifo_bypass      = pwdata[phy_tuning_pkg::RL_FIFO_BYPASS_BIT];
                  cfg_d.bypass_clk_delay = pwdata[phy_tuning_pkg::RL_CLK_DELAY_BIT];
                  cfg_d.low_latency      = pwdata[phy_tuning_pkg::RL_LOW_LAT_BIT];
               end
            end
            phy_tuning_pkg::IDX_FE_RX_CONFIG: begin
               if (pstrb[1]) begin
                  cfg_d.watchdog_disable = pwdata[phy_tuning_pkg::FE_WDOG_DIS_BIT];
                  cfg_d.recovery_time[3:1] = pwdata[phy_tuning_pkg::FE_RECOV_MSB:8];
               end
               if (lo_en) begin
                  cfg_d.recovery_time[0] = pwdata[phy_tuning_pkg::FE_RECOV_LSB];
                  cfg_d.force_link    = pwdata[phy_tuning_pkg::FE_FORCE_LINK];
                  cfg_d.mlt3_enh      = pwdata[phy_tuning_pkg::FE_MLT3_BIT];
                  cfg_d.gap_enh       = pwdata[phy_tuning_pkg::FE_GAP_BIT];
                  cfg_d.scrambler_off = pwdata[phy_tuning_pkg::FE_SCR_OFF_BIT];
                  cfg_d.odd_nibble    = pwdata[phy_tuning_pkg::FE_ODD_NIB_BIT];
                  cfg_d.early_rxv     = pwdata[phy_tuning_pkg::FE_EARLY_RXV_BIT];
               end
            end
            phy_tuning_pkg::IDX_TRELLIS_CFG: begin
               if (lo_en) begin
                  cfg_d.idle_thresh = pwdata[phy_tuning_pkg::TD_THR_MSB:phy_tuning_pkg::TD_THR_LSB];
               end
            end
            default: begin
               // status registers: writes ignored
               cfg_d = cfg_q;
            end
         endcase
      end
   end

   // negotiation status follows the serial link
   always_comb begin
      page_d = sgmii_page_rx;
      done_d = sgmii_neg_done;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q                  <= '0;
         cfg_q.recovery_time    <= phy_tuning_pkg::RST_RECOVERY_TIME;
         cfg_q.mlt3_enh         <= phy_tuning_pkg::RST_MLT3_ENH;
         cfg_q.idle_thresh      <= phy_tuning_pkg::RST_IDLE_THRESH;
         page_q                 <= 1'b0;
         done_q                 <= 1'b0;
         prdata_q               <= 32'h0000_0000;
         slverr_q               <= 1'b0;
      end else begin
         cfg_q    <= cfg_d;
         page_q   <= page_d;
         done_q   <= done_d;
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
      end
   end

   // zero wait state: read data is combinational from the mux at the access edge
   assign prdata  = access ? {16'h0000, rd_word} : prdata_q;
   assign pslverr = access & ~hit;

   assign receive_fifo_bypass_enable         = cfg_q.fifo_bypass;
   assign bypass_receive_clock_delay_enable  = cfg_q.bypass_clk_delay;
   assign low_latency_enable                 = cfg_q.low_latency;
   assign force_link_good                    = cfg_q.force_link;
   assign enhanced_three_level_detect_enable = cfg_q.mlt3_enh;
   assign enhanced_gap_detect_enable         = cfg_q.gap_enh;
   assign scrambler_off                      = cfg_q.scrambler_off;
   assign odd_nibble_detect_enable           = cfg_q.odd_nibble;
   assign early_receive_valid_enable         = cfg_q.early_rxv;

   // descrambler watchdog and unlock recovery
   phy_tuning_pkg::rx_guard_e state_q, state_d;
   logic [31:0] wd_q, wd_d;
   logic [31:0] ms_q, ms_d;
   logic [3:0]  rec_q, rec_d;
   logic        abort_q, abort_d;

   always_comb begin
      state_d = state_q;
      wd_d    = wd_q;
      ms_d    = ms_q;
      rec_d   = rec_q;
      abort_d = 1'b0;
      case (state_q)
         phy_tuning_pkg::RX_IDLE: begin
            wd_d = 32'h0000_0000;
            if (!descrambler_locked) begin
               state_d = phy_tuning_pkg::RX_RECOVER;
               ms_d    = 32'h0000_0000;
               rec_d   = cfg_q.recovery_time;
            end else if (rx_packet_active) begin
               state_d = phy_tuning_pkg::RX_FRAME;
            end
         end
         phy_tuning_pkg::RX_FRAME: begin
            wd_d = wd_q + 32'h0000_0001;
            if (!rx_packet_active) begin
               state_d = phy_tuning_pkg::RX_IDLE;
            end else if (!cfg_q.watchdog_disable && wd_q >= 32'(WATCHDOG_CYCLES - 1)) begin
               abort_d = 1'b1;
               state_d = phy_tuning_pkg::RX_RECOVER;
               ms_d    = 32'h0000_0000;
               rec_d   = cfg_q.recovery_time;
            end
         end
         phy_tuning_pkg::RX_RECOVER: begin
            if (rec_q == 4'h0) begin
               if (descrambler_locked) begin
                  state_d = phy_tuning_pkg::RX_IDLE;
               end
            end else if (ms_q >= 32'(MS_CYCLES - 1)) begin
               ms_d  = 32'h0000_0000;
               rec_d = rec_q - 4'h1;
            end else begin
               ms_d = ms_q + 32'h0000_0001;
            end
         end
         default: begin
            state_d = phy_tuning_pkg::RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= phy_tuning_pkg::RX_IDLE;
         wd_q    <= 32'h0000_0000;
         ms_q    <= 32'h0000_0000;
         rec_q   <= 4'h0;
         abort_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wd_q    <= wd_d;
         ms_q    <= ms_d;
         rec_q   <= rec_d;
         abort_q <= abort_d;
      end
   end

   assign rx_packet_abort = abort_q;
   assign rx_recovering   = (state_q == phy_tuning_pkg::RX_RECOVER);

   // trellis idle detector: consecutive idle symbols
   logic [3:0] idle_cnt_q, idle_cnt_d;
   logic       idle_q, idle_d;

   always_comb begin
      idle_cnt_d = idle_cnt_q;
      idle_d     = idle_q;
      if (rx_symbol_valid) begin
         if (!rx_symbol_idle) begin
            idle_cnt_d = 4'h0;
            idle_d     = 1'b0;
         end else if (idle_cnt_q < cfg_q.idle_thresh) begin
            idle_cnt_d = idle_cnt_q + 4'h1;
            idle_d     = (idle_cnt_q + 4'h1) >= cfg_q.idle_thresh;
         end else begin
            idle_d = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_q <= 4'h0;
         idle_q     <= 1'b0;
      end else begin
         idle_cnt_q <= idle_cnt_d;
         idle_q     <= idle_d;
      end
   end

   assign idle_mode = idle_q;

endmodule : phy_datapath_tuning_regs

// ### phy_datapath_tuning_regs_chk.sv
// checker for the datapath tuning register bank, apb side and datapath outputs
// assumes it is bound to the bank top and sees only its ports
module phy_datapath_tuning_regs_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        sgmii_page_rx,
   input wire logic        sgmii_neg_done,
   input wire logic        rx_symbol_valid,
   input wire logic        rx_symbol_idle,
   input wire logic        receive_fifo_bypass_enable,
   input wire logic        bypass_receive_clock_delay_enable,
   input wire logic        low_latency_enable,
   input wire logic        enhanced_three_level_detect_enable,
   input wire logic        scrambler_off,
   input wire logic        early_receive_valid_enable,
   input wire logic        rx_packet_abort,
   input wire logic        rx_recovering,
   input wire logic        idle_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic        wr;
   logic        rd;
   logic [11:0] ix;
   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && penable && !pwrite && pready;
   assign ix = paddr[13:2];
   property p_bypass;
      wr && ix == 12'h033 && pstrb[0] |=> receive_fifo_bypass_enable == $past(pwdata[4]);
   endproperty
   a_bypass: assert property (p_bypass) else $error("fifo bypass output wrong");
   property p_delay;
      wr && ix == 12'h033 && pstrb[0] |=> bypass_receive_clock_delay_enable == $past(pwdata[3]);
   endproperty
   a_delay: assert property (p_delay) else $error("clock delay output wrong");
   property p_low;
      wr && ix == 12'h033 && pstrb[0] |=> low_latency_enable == $past(pwdata[2]);
   endproperty
   a_low: assert property (p_low) else $error("low latency output wrong");
   property p_early;
      wr && ix == 12'h043 && pstrb[0] |=> early_receive_valid_enable == $past(pwdata[0]);
   endproperty
   a_early: assert property (p_early) else $error("early valid output wrong");
   property p_sts;
      rd && ix == 12'h037 |-> prdata[1:0] == {$past(sgmii_page_rx), $past(sgmii_neg_done)};
   endproperty
   a_sts: assert property (p_sts) else $error("negotiation status wrong");
   property p_zero;
      rd && ix == 12'h037 |-> prdata[31:2] == 30'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("status upper bits not zero");
   property p_rsvd;
      rd && ix == 12'h033 |-> prdata[31:5] == 27'h0 && prdata[1:0] == 2'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved latency bits not zero");
   property p_idle;
      rx_symbol_valid && !rx_symbol_idle |=> !idle_mode;
   endproperty
   a_idle: assert property (p_idle) else $error("idle mode kept after busy symbol");
   property p_abort;
      rx_packet_abort |=> !rx_packet_abort && rx_recovering;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not a pulse into recovery");
   property p_rst;
      $rose(presetn) |-> enhanced_three_level_detect_enable && !scrambler_off && !idle_mode;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at defaults after reset");
   c_wr: cover property (wr);
   c_abort: cover property (rx_packet_abort);
   c_idle: cover property ($rose(idle_mode));
endmodule : phy_datapath_tuning_regs_chk

// ### phy_datapath_tuning_regs_test.sv
// testbench for the datapath tuning register bank with read scoreboard
// assumes the host model drives apb; bench drives the datapath inputs
module phy_datapath_tuning_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pg, dn, sv, si, pa, lk, ab, rec, idl;
   logic [8:0]  o;
   logic [15:0] fe;
   logic [31:0] d;
   logic [32:0] q[$];
   int          errors, n_tests, cyc, n;
   phy_datapath_tuning_regs #(.WATCHDOG_CYCLES(20), .MS_CYCLES(10)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sgmii_page_rx(pg), .sgmii_neg_done(dn), .rx_symbol_valid(sv),
      .rx_symbol_idle(si), .rx_packet_active(pa), .descrambler_locked(lk),
      .receive_fifo_bypass_enable(o[8]), .bypass_receive_clock_delay_enable(o[7]),
      .low_latency_enable(o[6]), .force_link_good(o[5]), .enhanced_three_level_detect_enable(o[4]),
      .enhanced_gap_detect_enable(o[3]), .scrambler_off(o[2]), .odd_nibble_detect_enable(o[1]),
      .early_receive_valid_enable(o[0]), .rx_packet_abort(ab), .rx_recovering(rec), .idle_mode(idl));
   apb_host_model u_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      if (errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task automatic rd(input logic [31:0] a, input logic [32:0] e);
      q.push_back(e);
      u_host.xfer(1'b0, a, 32'h0, 4'hF);
   endtask : rd
   task automatic sym(input int k, input logic idle);
      repeat (k) begin
         @(posedge pclk);
         sv <= 1'b1;
         si <= idle;
      end
      @(posedge pclk);
      sv <= 1'b0;
      #1;
   endtask : sym
   task automatic run_pkt();
      n = 0;
      @(posedge pclk);
      pa <= 1'b1;
      repeat (60) begin
         @(posedge pclk);
         #1 if (ab === 1'b1) n++;
      end
      pa <= 1'b0;
   endtask : run_pkt
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         report_and_stop();
      end
   end
   // scoreboard: each completed read takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         if (q.size() == 0) chk("read_queue", 33'h0, 33'h1FFFFFFFF);
         else chk("read", {pslverr, prdata}, q.pop_front());
      end
   end
   initial begin
      // descrambler starts locked so the watchdog packet is not swallowed by recovery
      {presetn, pg, dn, sv, si, pa, lk} = 7'h01;
      void'($urandom(24));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(32'h0CC, 33'h0);
      rd(32'h10C, 33'h7A0);
      rd(32'h14C, 33'h2055);
      rd(32'h0DC, 33'h0);
      rd(32'h200, 33'h100000000);
      u_host.xfer(1'b1, 32'h0CC, 32'hFFFF, 4'hF);
      rd(32'h0CC, 33'h1C);
      chk("rl_out", 33'(o[8:6]), 33'h7);
      u_host.xfer(1'b1, 32'h0DC, 32'hFFFF, 4'hF);
      rd(32'h0DC, 33'h0);
      fe = 16'h07A0;
      for (int i = 0; i < 6; i++) begin
         d = $urandom;
         if (i != 1) fe[7:0] = d[7:0];
         if (i != 0) fe[15:8] = d[15:8];
         fe &= 16'h0FF7;
         u_host.xfer(1'b1, 32'h10C, d, (i == 0) ? 4'h1 : (i == 1) ? 4'h2 : 4'hF);
         rd(32'h10C, {17'h0, fe});
         chk("fe_out", 33'(o[5:0]), 33'({fe[6:4], fe[2:0]}));
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         {pg, dn} <= 2'(i);
         rd(32'h0DC, 33'(i));
      end
      u_host.set_threshold(8);
      rd(32'h14C, 33'h2054);
      sym(3, 1'b1);
      chk("idle3", 33'(idl), 33'h0);
      sym(1, 1'b0);
      sym(4, 1'b1);
      chk("idle4", 33'(idl), 33'h1);
      rd(32'h110, 33'h1);
      sym(1, 1'b0);
      chk("idle_clr", 33'(idl), 33'h0);
      lk <= 1'b1;
      u_host.xfer(1'b1, 32'h10C, 32'h0780, 4'hF);
      run_pkt();
      chk("abort", 33'(n), 33'h1);
      chk("recov", 33'(rec), 33'h1);
      repeat (200) @(posedge pclk);
      #1 chk("recov_end", 33'(rec), 33'h0);
      u_host.xfer(1'b1, 32'h10C, 32'h0F80, 4'hF);
      run_pkt();
      chk("no_abort", 33'(n), 33'h0);
      @(posedge pclk);
      lk <= 1'b0;
      @(posedge pclk);
      lk <= 1'b1;
      repeat (2) @(posedge pclk);
      #1 chk("unlock", 33'(rec), 33'h1);
      rd(32'h110, 33'h2);
      report_and_stop();
   end
endmodule : phy_datapath_tuning_regs_test
bind phy_datapath_tuning_regs phy_datapath_tuning_regs_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .sgmii_page_rx(sgmii_page_rx), .sgmii_neg_done(sgmii_neg_done),
   .rx_symbol_valid(rx_symbol_valid), .rx_symbol_idle(rx_symbol_idle),
   .receive_fifo_bypass_enable(receive_fifo_bypass_enable),
   .bypass_receive_clock_delay_enable(bypass_receive_clock_delay_enable),
   .low_latency_enable(low_latency_enable),
   .enhanced_three_level_detect_enable(enhanced_three_level_detect_enable),
   .scrambler_off(scrambler_off), .early_receive_valid_enable(early_receive_valid_enable),
   .rx_packet_abort(rx_packet_abort), .rx_recovering(rx_recovering), .idle_mode(idle_mode));

// ### phy_tuning_pkg.sv
// package for the datapath tuning register bank: offsets, field positions, reset values
// assumes a 32-bit apb slave, one aligned word per register
package phy_tuning_pkg;

   // printed offsets are not all multiples of four: indices, byte address is index * 4
   localparam logic [11:0] IDX_RGMII_LATENCY  = 12'h033;
   localparam logic [11:0] IDX_SERIAL_NEG_STS = 12'h037;
   localparam logic [11:0] IDX_FE_RX_CONFIG   = 12'h043;
   localparam logic [11:0] IDX_TRELLIS_CFG    = 12'h053;
   // own offset for the internal receive status: descrambler recovery and trellis idle mode
   localparam logic [11:0] IDX_FE_RX_STATUS   = 12'h044;

   // rgmii_latency_control fields
   localparam int RL_FIFO_BYPASS_BIT = 4;
   localparam int RL_CLK_DELAY_BIT   = 3;
   localparam int RL_LOW_LAT_BIT     = 2;

   // serial_link_negotiation_status fields
   localparam int NS_PAGE_RX_BIT = 1;
   localparam int NS_DONE_BIT    = 0;

   // fast_ethernet_receive_config fields
   localparam int FE_WDOG_DIS_BIT  = 11;
   localparam int FE_RECOV_MSB     = 10;
   localparam int FE_RECOV_LSB     = 7;
   localparam int FE_FORCE_LINK    = 6;
   localparam int FE_MLT3_BIT      = 5;
   localparam int FE_GAP_BIT       = 4;
   localparam int FE_SCR_OFF_BIT   = 2;
   localparam int FE_ODD_NIB_BIT   = 1;
   localparam int FE_EARLY_RXV_BIT = 0;

   // trellis_detector_config fields
   localparam int TD_THR_MSB = 3;
   localparam int TD_THR_LSB = 0;

   // reset values
   localparam logic [3:0]  RST_RECOVERY_TIME = 4'hF;
   localparam logic        RST_MLT3_ENH      = 1'b1;
   localparam logic [3:0]  RST_IDLE_THRESH   = 4'h5;
   localparam logic [11:0] TD_FIXED_UPPER    = 12'h205;

   // timing
   localparam int CLK_HZ            = 50_000_000;
   localparam int WATCHDOG_US       = 1500;
   localparam int WATCHDOG_CYCLES   = (WATCHDOG_US * (CLK_HZ / 1_000_000));
   localparam int MS_US             = 1000;
   localparam int MS_CYCLES         = (MS_US * (CLK_HZ / 1_000_000));

   typedef struct packed {
      logic       fifo_bypass;
      logic       bypass_clk_delay;
      logic       low_latency;
      logic       watchdog_disable;
      logic [3:0] recovery_time;
      logic       force_link;
      logic       mlt3_enh;
      logic       gap_enh;
      logic       scrambler_off;
      logic       odd_nibble;
      logic       early_rxv;
      logic [3:0] idle_thresh;
   } tuning_cfg_s;

   typedef enum logic [2:0] {
      RX_IDLE    = 3'b001,
      RX_FRAME   = 3'b010,
      RX_RECOVER = 3'b100
   } rx_guard_e;

endpackage : phy_tuning_pkg
